// [tblwt_defs.svh]
/*
 Timing counts, reset values and internal address limit for the table-write unit.
 Assumes inclusion by the unit and its bench only.
*/
`ifndef TBLWT_DEFS_SVH
`define TBLWT_DEFS_SVH
`define SHORT_WRITE_CYCLES 2
`define EXT_WRITE_CYCLES   2
`define LATCH_RESET        16'h0000
`define POINTER_RESET      16'h0000
`define INTERNAL_TOP_DEF   16'h3FFF
`endif

// [tblwt_pkg.sv]
/*
 Types for the table-write unit.
 Assumes nothing beyond the defines header.
*/
package tblwt_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXT,
        ST_PROG,
        ST_SHORT
    } wr_state_e;

    typedef struct packed {
        logic       byte_high;
        logic       hold_pointer;
        logic [7:0] file_value;
    } table_write_op_s;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
    } mem_word_s;
endpackage : tblwt_pkg

// [table_write_program_memory.sv]
/*
 Table-write execution unit: loads a latch byte, writes the 16-bit latch
 to program memory at the table pointer, then optionally advances it.
 Assumes the core issues one op pulse when idle and the interrupt and
 programming-voltage inputs arrive from outside the clock domain.
*/
// How it works
// - Full 16-bit latch written at pointer address
// - External write finishes in exactly two cycles
// - On-chip write runs until interrupt arrives
// - No programming voltage: two-cycle short write
// - Short write leaves on-chip word unchanged
// - Operand bit one holds pointer, zero increments
// - One word op, two or many cycles
// - Operand byte loads latch high or low
`timescale 1ns/1ns
`include "tblwt_defs.svh"
module table_write_program_memory
    import tblwt_pkg::*;
#(
    parameter logic [15:0] INTERNAL_TOP = `INTERNAL_TOP_DEF
) (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst_b,
    // Core request
    input  wire logic            op_valid,
    input  wire table_write_op_s table_write_op,
    output logic                 op_ready,
    output logic                 op_done,
    // Pins and events
    input  wire logic            interrupt_in,
    input  wire logic            reset_program_voltage_pin,
    // Program memory ports
    output logic                 ext_we,
    output logic                 int_prog_en,
    output mem_word_s            mem_word,
    // Visible state
    output logic [15:0]          program_write_latch,
    output logic [15:0]          table_address_pointer
);

    // ************************************
    // Input synchronisers
    // ************************************
    logic [1:0] irq_sync_r;
    logic [1:0] vpp_sync_r;
    logic       irq_seen;
    logic       vpp_ok;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            irq_sync_r <= 2'h0;
        else
            irq_sync_r <= {irq_sync_r[0], interrupt_in};
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            vpp_sync_r <= 2'h0;
        else
            vpp_sync_r <= {vpp_sync_r[0], reset_program_voltage_pin};
    end

    // Only the second stage is read, so no logic sees a metastable bit
    assign irq_seen = irq_sync_r[1];
    assign vpp_ok   = vpp_sync_r[1];

    // ************************************
    // Target decode
    // ************************************
    function automatic logic is_internal(input logic [15:0] a);
        is_internal = (a <= INTERNAL_TOP);
    endfunction : is_internal

    // Busy state entered when a request is taken
    function automatic wr_state_e start_state(input logic [15:0] a,
                                              input logic        v);
        if (!is_internal(a))
            start_state = ST_EXT;
        else if (v)
            start_state = ST_PROG;
        else
            start_state = ST_SHORT;
    endfunction : start_state

    // Last cycle of a fixed-length write
    function automatic logic timed_last(input wr_state_e  s,
                                        input logic [1:0] c);
        if (s == ST_EXT)
            timed_last = (c == 2'(`EXT_WRITE_CYCLES - 1));
        else if (s == ST_SHORT)
            timed_last = (c == 2'(`SHORT_WRITE_CYCLES - 1));
        else
            timed_last = 1'b0;
    endfunction : timed_last

    // ************************************
    // Request handshake
    // ************************************
    wr_state_e   state_r;
    logic        hold_r;
    logic [1:0]  cnt_r;
    logic [15:0] latch_nxt;
    logic        take;
    logic        finish;

    assign op_ready = (state_r == ST_IDLE);
    assign take     = op_valid && op_ready;
    assign finish   = timed_last(state_r, cnt_r)
                      || (state_r == ST_PROG && irq_seen);

    // ************************************
    // Latch load
    // ************************************
    always_comb begin
        latch_nxt = program_write_latch;
        if (table_write_op.byte_high)
            latch_nxt[15:8] = table_write_op.file_value;
        else
            latch_nxt[7:0] = table_write_op.file_value;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            program_write_latch <= `LATCH_RESET;
        else if (take)
            program_write_latch <= latch_nxt;
    end

    // ************************************
    // Write sequencer
    // ************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (take)
                        state_r <= start_state(table_address_pointer,
                                               vpp_ok);
                end
                ST_EXT, ST_SHORT: begin
                    if (timed_last(state_r, cnt_r))
                        state_r <= ST_IDLE;
                end
                ST_PROG: begin
                    if (irq_seen)
                        state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ************************************
    // Step counter
    // ************************************
    // Idle preloads the first step of a fixed-length write
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            cnt_r <= 2'h0;
        else if (state_r == ST_IDLE)
            cnt_r <= 2'h1;
        else if (state_r != ST_PROG)
            cnt_r <= cnt_r + 2'h1;
    end

    // ************************************
    // Operand hold
    // ************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            hold_r <= 1'b0;
        else if (take)
            hold_r <= table_write_op.hold_pointer;
    end

    // ************************************
    // Memory drive
    // ************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            ext_we <= 1'b0;
        else
            ext_we <= take && (start_state(table_address_pointer, vpp_ok)
                               == ST_EXT);
    end

    // A short write raises neither strobe, so the cell keeps its word
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            int_prog_en <= 1'b0;
        else if (take)
            int_prog_en <= (start_state(table_address_pointer, vpp_ok)
                            == ST_PROG);
        else
            int_prog_en <= (state_r == ST_PROG) && !irq_seen;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            mem_word <= '0;
        else if (take)
            mem_word <= '{addr: table_address_pointer,
                          data: latch_nxt};
    end

    // ************************************
    // Completion
    // ************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            op_done <= 1'b0;
        else
            op_done <= finish;
    end

    // ************************************
    // Pointer update
    // ************************************
    // Pointer moves with completion, so a refused request never moves it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            table_address_pointer <= `POINTER_RESET;
        else if (finish && !hold_r)
            table_address_pointer <= table_address_pointer + 16'h0001;
    end

endmodule : table_write_program_memory

// [table_write_program_memory_asserts.sv]
/* Port assertions for the table-write unit.
   Assumes it is bound onto every instance of the unit. */
`timescale 1ns/1ns
module table_write_program_memory_asserts
    import tblwt_pkg::*;
#(parameter logic [15:0] INTERNAL_TOP = 16'h3FFF) (
    // Clock, reset and request
    input wire logic            clk,
    input wire logic            rst_b,
    input wire logic            op_valid,
    input wire table_write_op_s table_write_op,
    input wire logic            op_ready,
    input wire logic            op_done,
    // Pins and memory side
    input wire logic            interrupt_in,
    input wire logic            reset_program_voltage_pin,
    input wire logic            ext_we,
    input wire logic            int_prog_en,
    input wire mem_word_s       mem_word,
    input wire logic [15:0]     program_write_latch,
    input wire logic [15:0]     table_address_pointer
);
    logic hold_r;
    wire logic take = op_valid && op_ready;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b) hold_r <= 1'b0;
        else if (take) hold_r <= table_write_op.hold_pointer;
    chk_ext_two: assert property (ext_we |=> op_done)
        else $error("external write length wrong");
    chk_ext_data: assert property (ext_we |-> mem_word.data ==
        program_write_latch && mem_word.addr == table_address_pointer)
        else $error("written word wrong");
    chk_prog_hold: assert property (int_prog_en && !interrupt_in &&
        !$past(interrupt_in) && !$past(interrupt_in, 2) |=> int_prog_en)
        else $error("programming ended early");
    chk_prog_end: assert property (int_prog_en && interrupt_in
        |-> ##[1:4] op_done) else $error("programming not ended");
    chk_short_write: assert property (take &&
        !$past(reset_program_voltage_pin, 2)
        && table_address_pointer <= INTERNAL_TOP
        |=> !ext_we && !int_prog_en ##1 op_done && !int_prog_en)
        else $error("short write wrong");
    chk_ptr_step: assert property (op_done |=> table_address_pointer ==
        $past(mem_word.addr) + 16'(!$past(hold_r)))
        else $error("pointer update wrong");
    chk_busy_once: assert property (take |=> !op_ready)
        else $error("ready while busy");
    chk_latch_load: assert property (take |=> program_write_latch ==
        ($past(table_write_op.byte_high) ?
        {$past(table_write_op.file_value), $past(program_write_latch[7:0])} :
        {$past(program_write_latch[15:8]), $past(table_write_op.file_value)}))
        else $error("latch load wrong");
endmodule : table_write_program_memory_asserts
bind table_write_program_memory table_write_program_memory_asserts
    #(.INTERNAL_TOP(INTERNAL_TOP)) u_chk (.clk, .rst_b, .op_valid,
    .table_write_op, .op_ready, .op_done, .interrupt_in,
    .reset_program_voltage_pin, .ext_we, .int_prog_en, .mem_word,
    .program_write_latch, .table_address_pointer);

// [prog_memory_model.sv]
/* Program memory model: external words and on-chip cells.
   Assumes the unit's memory outputs on the same clock. */
`timescale 1ns/1ns
module prog_memory_model
    import tblwt_pkg::*;
(
    // Unit side
    input  wire logic      clk,
    input  wire logic      ext_we,
    input  wire logic      int_prog_en,
    input  wire mem_word_s mem_word,
    // Programming finished event
    output logic           prog_irq
);
    logic [15:0] mem [0:15];
    logic [2:0]  cnt_r = 3'h0;
    initial prog_irq = 1'b0;
    initial for (int i = 0; i < 16; i++) mem[i] = 16'hFFFF;
    always @(posedge clk) begin
        if (ext_we || int_prog_en) mem[mem_word.addr[3:0]] <= mem_word.data;
        cnt_r <= int_prog_en ? cnt_r + 3'h1 : 3'h0;
        prog_irq <= int_prog_en && cnt_r == 3'h4;
    end
endmodule : prog_memory_model

// [tb_table_write_program_memory.sv]
/* Self-checking bench for the table-write unit.
   Assumes the unit, checker and memory model are compiled first. */
`timescale 1ns/1ns
`include "tblwt_defs.svh"
module tb_table_write_program_memory;
    import tblwt_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, op_valid = 1'b0;
    logic reset_program_voltage_pin = 1'b1;
    table_write_op_s table_write_op = '0;
    logic op_ready, op_done, interrupt_in, ext_we, int_prog_en;
    mem_word_s mem_word;
    logic [15:0] program_write_latch, table_address_pointer;
    int miscompares = 0, comparisons = 0;
    always #10 clk = ~clk;
    table_write_program_memory #(.INTERNAL_TOP(16'h0001)) dut (.clk,
        .rst_b, .op_valid, .table_write_op, .op_ready, .op_done,
        .interrupt_in, .reset_program_voltage_pin, .ext_we, .int_prog_en,
        .mem_word, .program_write_latch, .table_address_pointer);
    prog_memory_model mem_model (.clk, .ext_we, .int_prog_en, .mem_word,
        .prog_irq(interrupt_in));
    task check(string name, logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s exp %h seen %h", name, exp, seen);
        end
    endtask : check
    task final_report;
        if (miscompares == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report
    task run_op(logic bh, logic hold, logic [7:0] val, int cyc_exp);
        int cyc;
        cyc = 1;
        op_valid = 1'b1;
        table_write_op = '{bh, hold, val};
        @(negedge clk);
        op_valid = 1'b0;
        while (op_done !== 1'b1 && cyc < 20) begin
            @(negedge clk);
            cyc++;
        end
        check("done", 16'(op_done), 16'h0001);
        check("cycles", 16'(cyc), 16'(cyc_exp));
        @(negedge clk);
    endtask : run_op
    // ****
    // Scenarios
    // ****
    task reset_values;
        check("ready", 16'(op_ready), 16'h0001);
        check("rst ptr", table_address_pointer, `POINTER_RESET);
        check("rst latch", program_write_latch, `LATCH_RESET);
        check("rst we", 16'({ext_we, int_prog_en}), 16'h0000);
    endtask : reset_values
    task on_chip_write;
        run_op(1'b1, 1'b1, 8'hAB, 9);
        run_op(1'b0, 1'b0, 8'hCD, 9);
        check("mem0", mem_model.mem[0], 16'hABCD);
        check("ptr", table_address_pointer, 16'h0001);
    endtask : on_chip_write
    task short_write;
        reset_program_voltage_pin = 1'b0;
        repeat (3) @(negedge clk);
        run_op(1'b1, 1'b0, 8'h12, `SHORT_WRITE_CYCLES);
        check("mem1", mem_model.mem[1], 16'hFFFF);
        check("latch", program_write_latch, 16'h12CD);
        reset_program_voltage_pin = 1'b1;
        repeat (3) @(negedge clk);
    endtask : short_write
    task ext_write;
        run_op(1'b0, 1'b1, 8'h34, `EXT_WRITE_CYCLES);
        check("mem2", mem_model.mem[2], 16'h1234);
        check("ptr", table_address_pointer, 16'h0002);
        run_op(1'b0, 1'b0, 8'h56, `EXT_WRITE_CYCLES);
        check("mem2b", mem_model.mem[2], 16'h1256);
        check("ptr2", table_address_pointer, 16'h0003);
    endtask : ext_write
    initial begin
        #20000;
        miscompares++;
        final_report();
    end
    initial begin
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        reset_values();
        on_chip_write();
        short_write();
        ext_write();
        final_report();
    end
endmodule : tb_table_write_program_memory
